// ==== hw/rea_accumulator.sv ====
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rea_consts.svh"


module rea_accumulator #(
    parameter int SETTLE_CYCLES = `REA_SIGN_SETTLE_MS * `REA_CLK_KHZ
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Filtered reactive products, same clock
    input wire logic signed [`REA_IN_W-1:0] va_ia,
    input wire logic signed [`REA_IN_W-1:0] va_ib,
    input wire logic signed [`REA_IN_W-1:0] vb_ib,
    input wire logic signed [`REA_IN_W-1:0] vc_ic,
    input wire logic signed [`REA_IN_W-1:0] vc_ib,
    // Interrupt
    output logic irq_n
);
    import rea_pkg::*;

    rea_regs_t st;
    rea_regs_t nx;

    logic addr_ph;
    logic mapped;
    logic [5:0] idx;
    logic clr_sts;
    logic hf_evt;
    logic sc_evt;
    logic [2:0] rd_clr;
    logic [2:0] sc_pulse;
    logic signed [13:0] gfac;
    logic signed [39:0] prod;
    logic [`REA_ACC_W-1:0] acc_new;
    logic signed [24:0] raw [3];
    logic signed [25:0] corr [3];
    logic signed [`REA_PWR_W-1:0] scaled [3];
    logic signed [`REA_PWR_W-1:0] addend [3];

    function automatic logic hit3(logic [5:0] i, logic [5:0] base);
        return i >= base && i < base + 6'h3;
    endfunction

    function automatic logic [1:0] slot(logic [5:0] i, logic [5:0] base);
        return 2'(i - base);
    endfunction

    function automatic logic [31:0] reg_read(rea_regs_t s, logic [5:0] i);
        logic [31:0] d;
        d = 32'h0;
        if (hit3(i, `REA_IDX_GAIN)) begin
            d[11:0] = s.gain[slot(i, `REA_IDX_GAIN)];
        end else if (hit3(i, `REA_IDX_OFFS)) begin
            d[11:0] = s.offs[slot(i, `REA_IDX_OFFS)];
        end else if (hit3(i, `REA_IDX_ENERGY)) begin
            d[15:0] = s.acc[slot(i, `REA_IDX_ENERGY)][`REA_ACC_W-1:`REA_ENERGY_LSB];
        end else if (i == `REA_IDX_DIVIDER) begin
            d[7:0] = s.div;
        end else if (i == `REA_IDX_COMP_MODE) begin
            d[4:0] = s.comp;
        end else if (i == `REA_IDX_LINE_MODE) begin
            d[`REA_READ_RESET_BIT] = s.read_reset;
        end else if (i == `REA_IDX_STATUS) begin
            d[`REA_HALF_FULL_BIT] = s.sts_hf;
            d[`REA_SIGN_CHG_BIT] = s.sts_sc;
        end else if (i == `REA_IDX_MASK) begin
            d[`REA_HALF_FULL_BIT] = s.msk_hf;
            d[`REA_SIGN_CHG_BIT] = s.msk_sc;
        end
        return d;
    endfunction

    always_comb begin
        nx = st;
        nx.hreadyout = 1'b1;
        gfac = '0;
        prod = '0;
        acc_new = '0;
        hf_evt = 1'b0;
        rd_clr = 3'b000;
        clr_sts = 1'b0;

        // Address phase; side effects of reads happen here
        addr_ph = hsel && htrans[1] && hready;
        idx = haddr[7:2];
        mapped = haddr[31:8] == 24'h0 && idx <= `REA_IDX_MASK;
        nx.dp_valid = addr_ph && mapped;
        nx.dp_write = hwrite;
        nx.dp_idx = idx;
        if (addr_ph && !hwrite) begin
            nx.hrdata = mapped ? reg_read(st, idx) : 32'h0;
            if (mapped && idx == `REA_IDX_STATUS) begin
                clr_sts = 1'b1;
            end
            if (mapped && hit3(idx, `REA_IDX_ENERGY) && st.read_reset) begin
                rd_clr[slot(idx, `REA_IDX_ENERGY)] = 1'b1;
            end
        end

        // Data phase writes
        if (st.dp_valid && st.dp_write) begin
            if (hit3(st.dp_idx, `REA_IDX_GAIN)) begin
                nx.gain[slot(st.dp_idx, `REA_IDX_GAIN)] = hwdata[11:0];
            end else if (hit3(st.dp_idx, `REA_IDX_OFFS)) begin
                nx.offs[slot(st.dp_idx, `REA_IDX_OFFS)] = hwdata[11:0];
            end else if (st.dp_idx == `REA_IDX_DIVIDER) begin
                nx.div = hwdata[7:0];
            end else if (st.dp_idx == `REA_IDX_COMP_MODE) begin
                nx.comp = hwdata[4:0];
            end else if (st.dp_idx == `REA_IDX_LINE_MODE) begin
                nx.read_reset = hwdata[`REA_READ_RESET_BIT];
            end else if (st.dp_idx == `REA_IDX_MASK) begin
                nx.msk_hf = hwdata[`REA_HALF_FULL_BIT];
                nx.msk_sc = hwdata[`REA_SIGN_CHG_BIT];
            end
        end

        // Sample tick, one every four clocks
        nx.tick_cnt = st.tick_cnt + 2'h1;
        nx.tick = st.tick_cnt == `REA_TICK_LAST;

        // Input selection; inputs already carry the current-channel gain
        case (rea_wiring_t'(st.comp[1:0]))
            REA_WIRE_OWN: begin
                raw[0] = 25'(va_ia);
                raw[1] = 25'(vb_ib);
                raw[2] = 25'(vc_ic);
            end
            REA_WIRE_DIFF_AC: begin
                raw[0] = 25'(va_ia) - 25'(va_ib);
                raw[1] = '0;
                raw[2] = 25'(vc_ic) - 25'(vc_ib);
            end
            REA_WIRE_DIFF_A: begin
                raw[0] = 25'(va_ia) - 25'(va_ib);
                raw[1] = '0;
                raw[2] = 25'(vc_ic);
            end
            default: begin
                // Reserved code zeroes the inputs; only the offsets still accumulate
                raw[0] = '0;
                raw[1] = '0;
                raw[2] = '0;
            end
        endcase

        for (int i = 0; i < 3; i++) begin
            corr[i] = 26'(raw[i]) + 26'($signed(st.offs[i]));
            gfac = $signed(`REA_GAIN_ONE + {{2{st.gain[i][11]}}, st.gain[i]});
            // Reactive gain on top of current gain; no sign flip on the way
            prod = 40'(corr[i]) * 40'(gfac);
            scaled[i] = `REA_PWR_W'(prod >>> `REA_GAIN_SHIFT);
            if (st.div > 8'h01) begin
                addend[i] = `REA_PWR_W'(scaled[i] / $signed({1'b0, st.div}));
            end else begin
                addend[i] = scaled[i];
            end
            // Plain modular add: the readable word wraps with no saturation
            acc_new = st.acc[i] + `REA_ACC_W'(addend[i]);
            if (rd_clr[i]) begin
                nx.acc[i] = '0;
            end else if (st.tick) begin
                nx.acc[i] = acc_new;
                if (acc_new[`REA_ACC_HALF_BIT] != st.acc[i][`REA_ACC_HALF_BIT]) begin
                    hf_evt = 1'b1;
                end
            end
        end

        // Sticky status; a new event wins over the read clear
        sc_evt = |(sc_pulse & st.comp[4:2]);
        nx.sts_hf = (st.sts_hf && !clr_sts) || hf_evt;
        nx.sts_sc = (st.sts_sc && !clr_sts) || sc_evt;
        nx.irq_n = !((nx.sts_hf && nx.msk_hf) || (nx.sts_sc && nx.msk_sc));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.irq_n <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    generate
        for (genvar g = 0; g < 3; g++) begin : g_sign
            rea_sign_det #(
                .SETTLE_CYCLES(SETTLE_CYCLES)
            ) u_sign (
                .clock(clock),
                .rst_n(rst_n),
                .tick(st.tick),
                .enable(st.comp[`REA_INCLUDE_LSB + g]),
                .power(scaled[g]),
                .change(sc_pulse[g])
            );
        end
    endgenerate

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = 1'b0;
    assign irq_n = st.irq_n;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_TICK_PERIOD: assert property (st.tick |=> !st.tick [*3] ##1 st.tick)
        else $error("sample tick not every four clocks");
    AST_ACC_HOLD: assert property (!st.tick && !rd_clr[0] |=> $stable(st.acc[0]))
        else $error("accumulator moved between ticks");
    AST_ACC_STEP: assert property (st.tick && !rd_clr[0]
        |=> st.acc[0] == $past(st.acc[0]) + `REA_ACC_W'($past(addend[0])))
        else $error("accumulator did not add signed sample");
    AST_RD_RESET: assert property (rd_clr[1] |=> st.acc[1] == '0)
        else $error("energy not cleared after read");
    AST_DIV_BYPASS: assert property (st.div <= 8'h01 |-> addend[2] == scaled[2])
        else $error("divider 0 or 1 did not bypass");
    AST_GAIN_UNITY: assert property (st.gain[0] == 12'h000
        |-> scaled[0] == `REA_PWR_W'(corr[0]))
        else $error("zero gain changed the power");
    AST_WIRE_B_ZERO: assert property (st.comp[1:0] != 2'b00 |-> raw[1] == '0)
        else $error("phase B input not zero in difference wiring");
    AST_HF_SET: assert property (hf_evt |=> st.sts_hf)
        else $error("half-full event lost");
    AST_SC_SET: assert property (sc_evt |=> st.sts_sc && (!st.irq_n || !st.msk_sc))
        else $error("sign change event lost");
    AST_IRQ_SC: assert property (st.sts_sc && st.msk_sc |-> !st.irq_n)
        else $error("unmasked sign flag without interrupt");
    AST_IRQ_IDLE: assert property (!(st.sts_sc && st.msk_sc)
        && !(st.sts_hf && st.msk_hf) |-> st.irq_n)
        else $error("interrupt without unmasked flag");

    COV_SIGN: cover property (sc_evt);
    COV_HALF: cover property (hf_evt);
    COV_RD_CLR: cover property (rd_clr[0]);
    COV_IRQ: cover property ($fell(st.irq_n));
endmodule

// ==== hw/rea_sign_det.sv ====
`timescale 1ns/1ps
`include "rea_consts.svh"

module rea_sign_det #(
    parameter int SETTLE_CYCLES = `REA_SIGN_SETTLE_MS * `REA_CLK_KHZ
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sample stream
    input wire logic tick,
    input wire logic enable,
    input wire logic signed [`REA_PWR_W-1:0] power,
    // Event
    output logic change
);
    import rea_pkg::*;

    rea_sd_t st;
    rea_sd_t nx;
    logic neg;
    logic [`REA_PWR_W-1:0] mag;
    logic [27:0] sum;

    always_comb begin
        nx = st;
        nx.evt = 1'b0;
        neg = power[`REA_PWR_W-1];
        mag = neg ? `REA_PWR_W'(-power) : `REA_PWR_W'(power);
        sum = {2'b00, st.integ} + {1'b0, mag};
        case (st.st)
            REA_SD_IDLE: begin
                // Excluded phases follow silently so no stale flip fires later
                if (!enable) begin
                    nx.held = neg;
                end else if (tick && neg != st.held) begin
                    nx.st = REA_SD_SETTLE;
                    nx.cnt = '0;
                end
            end
            REA_SD_SETTLE: begin
                nx.cnt = st.cnt + 24'h1;
                if (!enable || neg == st.held) begin
                    nx.st = REA_SD_IDLE;
                end else if (st.cnt == 24'(SETTLE_CYCLES - 1)) begin
                    nx.st = REA_SD_INTEG;
                    nx.integ = '0;
                end
            end
            REA_SD_INTEG: begin
                // Small inputs need longer to fill, hence the magnitude-dependent delay
                if (!enable || neg == st.held) begin
                    nx.st = REA_SD_IDLE;
                end else if (tick) begin
                    if (sum >= `REA_SIGN_LIMIT) begin
                        nx.evt = 1'b1;
                        nx.held = neg;
                        nx.st = REA_SD_IDLE;
                    end else begin
                        nx.integ = sum[25:0];
                    end
                end
            end
            default: begin
                nx.st = REA_SD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign change = st.evt;

    AST_SD_AFTER_INTEG: assert property (@(posedge clock) disable iff (!rst_n)
        st.evt |-> $past(st.st) == REA_SD_INTEG && $past(enable))
        else $error("sign change reported without settle and integration");
endmodule

// ==== pkg/rea_consts.svh ====
`ifndef REA_CONSTS_SVH
`define REA_CONSTS_SVH

// Word indices; the byte address is four times the index
`define REA_IDX_GAIN 6'h00
`define REA_IDX_OFFS 6'h03
`define REA_IDX_ENERGY 6'h06
`define REA_IDX_DIVIDER 6'h09
`define REA_IDX_COMP_MODE 6'h0A
`define REA_IDX_LINE_MODE 6'h0B
`define REA_IDX_STATUS 6'h0C
`define REA_IDX_MASK 6'h0D

// Field positions
`define REA_WIRING_LSB 0
`define REA_INCLUDE_LSB 2
`define REA_READ_RESET_BIT 6
`define REA_HALF_FULL_BIT 1
`define REA_SIGN_CHG_BIT 18

// Datapath
`define REA_IN_W 24
`define REA_PWR_W 27
`define REA_ACC_W 41
`define REA_ENERGY_LSB 25
`define REA_ACC_HALF_BIT 39
`define REA_GAIN_ONE 14'h1000
`define REA_GAIN_SHIFT 12
`define REA_TICK_LAST 2'h3

// Sign detection timing
`define REA_SIGN_SETTLE_MS 160
`define REA_CLK_KHZ 100000
`define REA_SIGN_LIMIT 28'h2000000

`endif

// ==== pkg/rea_pkg.sv ====
package rea_pkg;

    typedef enum logic [1:0] {
        REA_WIRE_OWN,
        REA_WIRE_DIFF_AC,
        REA_WIRE_DIFF_A,
        REA_WIRE_RSVD
    } rea_wiring_t;

    typedef enum logic [1:0] {
        REA_SD_IDLE,
        REA_SD_SETTLE,
        REA_SD_INTEG
    } rea_sd_state_t;

    typedef struct packed {
        rea_sd_state_t st;
        logic held;
        logic [23:0] cnt;
        logic [25:0] integ;
        logic evt;
    } rea_sd_t;

    typedef struct packed {
        logic hreadyout;
        logic dp_valid;
        logic dp_write;
        logic [5:0] dp_idx;
        logic [31:0] hrdata;
        logic [2:0][11:0] gain;
        logic [2:0][11:0] offs;
        logic [7:0] div;
        logic [4:0] comp;
        logic read_reset;
        logic sts_hf;
        logic sts_sc;
        logic msk_hf;
        logic msk_sc;
        logic [1:0] tick_cnt;
        logic tick;
        logic [2:0][40:0] acc;
        logic irq_n;
    } rea_regs_t;

endpackage

// ==== tb/rea_tb.sv ====
`timescale 1ns/1ps
module tb;
import rea_pkg::*;
logic clock;
logic rst_n;
logic hsel;
logic hwrite;
logic hready;
logic [31:0] haddr;
logic [31:0] hwdata;
logic [31:0] hrdata;
logic [1:0] htrans;
logic [2:0] hsize;
logic hreadyout;
logic hresp;
logic irq_n;
logic signed [23:0] va_ia, va_ib, vb_ib, vc_ic, vc_ib;
int n_fail, compares, cyc, seed, t_addr;
int t_clr[3];
int gn[3];
int of[3];
int dv;
longint inp[3];
logic [31:0] rd;
logic [31:0] msk[15] = '{32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'h0, 32'h0,
    32'h0, 32'hFF, 32'h1F, 32'h40, 32'h0, 32'h40002, 32'h0};
logic [11:0] cg[4] = '{12'h7FF, 12'h800, 12'h0A5, 12'h000};
logic [11:0] co[4] = '{12'h123, 12'hEDC, 12'h7FF, 12'h05A};
int cw[4] = '{0, 1, 3, 2};
int cd[4] = '{0, 1, 2, 3};

rea_accumulator #(.SETTLE_CYCLES(20)) rea_accumulator_inst (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .va_ia(va_ia), .va_ib(va_ib), .vb_ib(vb_ib),
    .vc_ic(vc_ic), .vc_ib(vc_ib), .irq_n(irq_n)
);
assign hready = hreadyout;

initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
end

task automatic close_out;
    $display("TB: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask

// Hang guard, well above the roughly 1700 cycles the run needs
always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc >= 8000) begin
        n_fail++;
        close_out();
    end
end

task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
        n_fail++;
        $display("ERROR %s expected %h got %h", nm, exp, got);
    end
endtask

// Single AHB-Lite word transfer; writes leave one idle cycle for read-after-write
task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    t_addr = cyc;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    if (wr) @(posedge clock);
endtask

function automatic longint addend(int p);
    longint v;
    v = ((inp[p] + of[p]) * (4096 + gn[p])) >>> 12;
    if (dv > 1) v = v / dv;
    return v;
endfunction

function automatic logic [15:0] en(longint k, int p);
    return 16'((k * addend(p)) >>> 25);
endfunction

// Tick phase against the bus is unknown, so one tick either way is accepted
task automatic rd_en(int p, bit chkit, bit rr);
    longint e;
    longint k;
    logic [15:0] ex;
    bus(1'b0, 6'h06 + 6'(p), 32'h0);
    e = (t_addr - t_clr[p]) / 4;
    ex = en(e, p);
    for (k = e - 1; k <= e + 1; k++) begin
        if (k >= 0 && en(k, p) === rd[15:0]) ex = rd[15:0];
    end
    if (chkit) chk("energy", {16'h0, ex}, rd);
    if (rr) t_clr[p] = t_addr;
endtask

initial begin
    int i, c, p;
    logic [31:0] w;
    logic [31:0] rv[5];
    seed = 91897;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {va_ia, va_ib, vb_ib, vc_ic, vc_ib} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 14; i++) begin
        bus(1'b0, 6'(i), 32'h0);
        chk("reset value", 32'h0, rd);
    end
    chk("irq_n idle", 32'h1, {31'h0, irq_n});
    // Random writes show field widths, read-only words and the unmapped index
    // Descending, so energy and status are read before the offsets go live
    for (i = 14; i >= 0; i--) begin
        w = $random(seed);
        bus(1'b1, 6'(i), w);
        bus(1'b0, 6'(i), 32'h0);
        chk("readback", w & msk[i], rd);
    end
    for (i = 0; i < 14; i++) bus(1'b1, 6'(i), 32'h0);
    repeat (50) @(posedge clock);
    bus(1'b0, 6'h0C, 32'h0);
    // Start A and B from zero so their first negative tick flips energy bit 14
    bus(1'b1, 6'h0B, 32'h40);
    bus(1'b0, 6'h06, 32'h0);
    bus(1'b0, 6'h07, 32'h0);
    bus(1'b1, 6'h0B, 32'h0);
    // Sign change on included phase A with the flag unmasked
    bus(1'b1, 6'h0D, 32'h40000);
    bus(1'b1, 6'h0A, 32'h4);
    bus(1'b0, 6'h0C, 32'h0);
    va_ia <= -24'sh400000;
    repeat (15) @(posedge clock);
    chk("irq_n early", 32'h1, {31'h0, irq_n});
    repeat (120) @(posedge clock);
    chk("irq_n raised", 32'h0, {31'h0, irq_n});
    bus(1'b0, 6'h0C, 32'h0);
    chk("status", 32'h40002, rd);
    @(posedge clock);
    chk("irq_n cleared", 32'h1, {31'h0, irq_n});
    // Phase A excluded, then B included with the flag masked off
    bus(1'b1, 6'h0D, 32'h0);
    bus(1'b1, 6'h0A, 32'h8);
    // Small positive flip keeps accumulator A below zero, so no half-full event
    va_ia <= 24'sh100000;
    repeat (150) @(posedge clock);
    bus(1'b0, 6'h0C, 32'h0);
    chk("status excluded", 32'h0, rd);
    vb_ib <= -24'sh400000;
    repeat (150) @(posedge clock);
    chk("irq_n masked", 32'h1, {31'h0, irq_n});
    bus(1'b0, 6'h0C, 32'h0);
    chk("status phase b", 32'h40002, rd);
    // Accumulation per wiring mode, gain extreme, offset and divider
    for (c = 0; c < 4; c++) begin
        for (p = 0; p < 3; p++) begin
            gn[p] = int'($signed(cg[c]));
            of[p] = int'($signed(co[c]));
            bus(1'b1, 6'(p), {20'h0, cg[c]});
            bus(1'b1, 6'h03 + 6'(p), {20'h0, co[c]});
        end
        dv = cd[c];
        bus(1'b1, 6'h09, 32'(dv));
        bus(1'b1, 6'h0A, 32'(cw[c]));
        bus(1'b1, 6'h0B, 32'h40);
        for (i = 0; i < 5; i++) rv[i] = $random(seed);
        va_ia <= rv[0][23:0];
        va_ib <= rv[1][23:0];
        vb_ib <= rv[2][23:0];
        vc_ic <= rv[3][23:0];
        vc_ib <= rv[4][23:0];
        inp[0] = (cw[c] == 0) ? $signed(rv[0][23:0]) : $signed(rv[0][23:0]) - $signed(rv[1][23:0]);
        inp[1] = (cw[c] == 0) ? $signed(rv[2][23:0]) : 0;
        inp[2] = (cw[c] == 1) ? $signed(rv[3][23:0]) - $signed(rv[4][23:0]) : $signed(rv[3][23:0]);
        if (cw[c] == 3) inp = '{0, 0, 0};
        @(posedge clock);
        for (p = 0; p < 3; p++) rd_en(p, 1'b0, 1'b1);
        if (c == 3) bus(1'b1, 6'h0B, 32'h0);
        repeat (200) @(posedge clock);
        for (p = 0; p < 3; p++) rd_en(p, 1'b1, c < 3);
        for (p = 0; p < 3; p++) rd_en(p, 1'b1, c < 3);
    end
    close_out();
end
endmodule
